// file: cts_pkg.sv
package cts_pkg;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_EVSEL = 8'h0c;
  localparam logic [7:0] A_TIM = 8'h10;
  localparam logic [7:0] A_SINGLE = 8'h14;
  localparam logic [7:0] A_SCANLO = 8'h18;
  localparam logic [7:0] A_SCANHI = 8'h1c;
  localparam logic [7:0] A_THR = 8'h20;
  localparam logic [7:0] A_BASE = 8'h24;
  localparam logic [7:0] A_DMCFG = 8'h28;
  localparam logic [7:0] A_DATA = 8'h2c;
  localparam logic [7:0] A_EMA = 8'h30;
  // Control register fields.
  localparam int CTRL_W = 19;
  localparam int F_SRC = 0;
  localparam int F_MODE = 2;
  localparam int F_DM = 4;
  localparam int F_RES = 5;
  localparam int F_KEEP = 7;
  localparam int F_FIXG = 8;
  localparam int F_SHIFT = 9;
  localparam int F_ACC = 10;
  localparam int F_POL = 13;
  localparam int F_EMA = 14;
  localparam int F_DMA = 17;
  localparam int F_BOND = 18;
  // Command and timer control fields.
  localparam int F_START = 0;
  localparam int F_STOP = 1;
  localparam int F_TOP = 0;
  localparam int F_PRESC = 8;
  localparam int F_WARM = 16;
  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 19'h00000;
  localparam logic [23:0] TIM_RST = 24'h0000ff;
  localparam logic [15:0] THR_RST = 16'h0000;
  // Timing counts in conversion clock ticks.
  localparam logic [8:0] WARM_BASE = 9'h003;
  localparam logic [7:0] DM_TESTS = 8'h40;
  localparam logic [3:0] DM_STEP_LEN = 4'hf;
  // Trigger sources and conversion modes.
  typedef enum logic [1:0] {SRC_SW, SRC_EVT, SRC_TMR, SRC_OFF} trig_src_t;
  typedef enum logic [1:0] {M_SINGLE, M_CSINGLE, M_SCAN, M_CSCAN} conv_mode_t;
endpackage

// file: cap_touch_unit.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
// Operation
// - At most one of software, event or timer source starts conversion cycles; the fourth setting starts none.
// - Writing one to the start command bit begins conversions in software mode.
// - An event on the selected event channel begins a cycle.
// - An 8-bit local counter makes triggers in timer mode.
// - Timer ticks come from the low-frequency clock divided by the prescaler.
// - Timer counts down from top value, fires at zero, then reloads.
// - One trigger yields one word or many words depending on mode.
// - Registers use the bus clock; the timer uses the low-frequency clock.
// - Conversions are timed by the conversion clock alone.
// - Up to 64 input channels can be measured.
// - Modes: single, continuous single, single scan, continuous scan.
// - SAR resolution is 10, 12, 14 or 16 bits.
// - Delta modulation uses reducing or fixed step, same resolutions.
// - Accumulate 1 to 64 samples, then shift or keep the 22-bit sum.
// - An exponential moving average filters results.
// - Results compare to a threshold with selectable polarity, flagging crossings.
// - Requests are raised on conversion done and on threshold crossing.
// - Bonding shorts selected channels and measures them together.
// - DMA requests move results out and load delta-modulation baselines.
// - After a trigger, wait three plus warm-up count ticks unless kept powered.
module cap_touch_unit
  import cts_pkg::*;
#(
  parameter int EVT_N = 8
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Slow clocks and event network.
  input wire logic low_freq_timer_clock,
  input wire logic conversion_clock,
  input wire logic [EVT_N-1:0] event_routing_network,
  // Analog core.
  input wire logic cmp_in,
  output logic pwr_on,
  output logic [63:0] ch_mask,
  output logic [15:0] dac_code,
  // Requests.
  output logic irq_done,
  output logic irq_cross,
  output logic dma_req,
  input wire logic dma_ack,
  output logic dma_base_req,
  input wire logic dma_base_wr,
  input wire logic [15:0] dma_base_data
);
  typedef enum logic [1:0] {ST_IDLE, ST_WARM, ST_CONV} state_t;
  localparam int SW = EVT_N + 3;

  // Refuse event channel counts the select field cannot reach.
  if (EVT_N < 1 || EVT_N > 8) begin : g_chk
    $error("EVT_N must lie between 1 and 8");
  end

  logic [CTRL_W-1:0] ctrl_q;
  logic [2:0] evsel_q;
  logic [23:0] tim_q;
  logic [5:0] single_q;
  logic [63:0] scan_q;
  logic [15:0] thr_q;
  logic [15:0] base_q;
  logic [7:0] dmg_q;
  logic [21:0] data_q;
  logic [21:0] ema_q;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [7:0] presc_q;
  logic [7:0] tmr_q;
  state_t st_q;
  logic [8:0] cnt_q;
  logic [15:0] step_q;
  logic [21:0] acc_q;
  logic [5:0] samp_q;
  logic [6:0] cur_q;
  logic [21:0] fin_q;
  logic out_q;
  logic above_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Decoded fields and strobes.
  trig_src_t src;
  conv_mode_t mode;
  logic [4:0] res_n;
  logic [2:0] acc_log;
  logic start_cmd;
  logic stop_cmd;
  assign src = trig_src_t'(ctrl_q[F_SRC+:2]);
  assign mode = conv_mode_t'(ctrl_q[F_MODE+:2]);
  assign res_n = 5'h0a + {2'h0, ctrl_q[F_RES+:2], 1'b0};
  assign acc_log = (ctrl_q[F_ACC+:3] > 3'h6) ? 3'h6 : ctrl_q[F_ACC+:3];
  assign start_cmd = wr && addr == A_CMD && wdata[F_START];
  assign stop_cmd = wr && addr == A_CMD && wdata[F_STOP];

  // Two-stage synchronisers for slow clocks, comparator and events.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= {low_freq_timer_clock, conversion_clock, cmp_in, event_routing_network};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic lf_rise;
  logic ctk;
  logic cmp_s;
  logic evt_rise;
  assign lf_rise = s2_q[SW-1] && !s3_q[SW-1];
  assign ctk = s2_q[SW-2] && !s3_q[SW-2];
  assign cmp_s = s2_q[EVT_N];
  assign evt_rise = s2_q[evsel_q] && !s3_q[evsel_q];

  logic [7:0] pmask;
  logic ptick;
  logic tmr_fire;
  assign pmask = 8'((9'h001 << tim_q[F_PRESC+:3]) - 9'h001);
  assign ptick = lf_rise && (presc_q & pmask) == pmask;
  assign tmr_fire = ptick && tmr_q == 8'h00;

  // Timer advances only on low-frequency clock edges.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_q <= 8'h00;
      tmr_q <= 8'hff;
    end
    else if (src != SRC_TMR)
    begin
      presc_q <= 8'h00;
      tmr_q <= tim_q[F_TOP+:8];
    end
    else
    begin
      if (lf_rise)
        presc_q <= presc_q + 8'h01;
      if (tmr_fire)
        tmr_q <= tim_q[F_TOP+:8];
      else if (ptick)
        tmr_q <= tmr_q - 8'h01;
    end
  end

  tmr_reload_a: assert property (tmr_fire |=> tmr_q == $past(tim_q[7:0]))
    else $error("timer did not reload at zero");
  tmr_count_a: assert property (ptick && tmr_q != 8'h00 && src == SRC_TMR
    |=> tmr_q == $past(tmr_q) - 8'h01)
    else $error("timer did not count down");

  logic trig;
  logic go;
  always_comb
  begin
    case (src)
      SRC_SW: trig = start_cmd;
      SRC_EVT: trig = evt_rise;
      SRC_TMR: trig = tmr_fire;
      default: trig = 1'b0;
    endcase
  end
  // Only an idle unit accepts a trigger.
  assign go = trig && st_q == ST_IDLE;

  // Lowest set channel at or above a start index; bit 6 set means none.
  function automatic logic [6:0] next_ch(input logic [63:0] m, input logic [6:0] from);
    logic [6:0] r;
    r = 7'h40;
    for (int i = 63; i >= 0; i--)
      if (m[i] && 7'(i) >= from)
        r = 7'(i);
    return r;
  endfunction

  // Conversion sequencing.
  logic scan;
  logic last;
  logic [3:0] bp;
  logic [21:0] acc_d;
  logic [15:0] res16;
  logic [6:0] nc;
  logic [6:0] first;
  logic [15:0] code_f;
  assign scan = mode[1] && !ctrl_q[F_BOND];
  assign bp = 4'(5'h0f - cnt_q[4:0]);
  assign last = ctrl_q[F_DM] ? cnt_q == {1'b0, DM_TESTS - 8'h01}
                             : cnt_q == {4'h0, res_n - 5'h01};
  // The last SAR test must decide the lowest result bit before the code is summed.
  always_comb
  begin
    code_f = dac_code;
    if (!ctrl_q[F_DM])
      code_f[bp] = cmp_s;
  end
  assign res16 = 16'(code_f >> (5'h10 - res_n));
  assign acc_d = acc_q + {6'h00, res16};
  assign nc = next_ch(scan_q, cur_q + 7'h01);
  assign first = next_ch(scan_q, 7'h00);

  // Selects the channels to connect for channel c.
  function automatic logic [63:0] pick(input logic bond, input logic [63:0] m,
                                       input logic [6:0] c);
    logic [63:0] r;
    r = bond ? m : (64'h1 << c[5:0]);
    return r;
  endfunction

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 9'h000;
      dac_code <= 16'h0000;
      step_q <= 16'h0000;
      acc_q <= 22'h000000;
      samp_q <= 6'h00;
      cur_q <= 7'h00;
      ch_mask <= 64'h0;
      pwr_on <= 1'b0;
      fin_q <= 22'h000000;
      out_q <= 1'b0;
    end
    else
    begin
      out_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          pwr_on <= ctrl_q[F_KEEP];
          cnt_q <= 9'h000;
          acc_q <= 22'h000000;
          samp_q <= 6'h00;
          dac_code <= ctrl_q[F_DM] ? base_q : 16'h8000;
          step_q <= 16'(dmg_q) << (5'h10 - res_n);
          if (go)
          begin
            // Pick single, scan or bonded channels.
            cur_q <= scan ? first : {1'b0, single_q};
            ch_mask <= pick(ctrl_q[F_BOND], scan_q, scan ? first : {1'b0, single_q});
            pwr_on <= 1'b1;
            st_q <= ctrl_q[F_KEEP] ? ST_CONV : ST_WARM;
          end
        end
        ST_WARM:
        begin
          if (ctk)
          begin
            cnt_q <= cnt_q + 9'h001;
            if (cnt_q == WARM_BASE + {1'b0, tim_q[F_WARM+:8]} - 9'h001)
            begin
              cnt_q <= 9'h000;
              st_q <= ST_CONV;
              // A baseline that arrived during warm-up is used by this conversion.
              dac_code <= ctrl_q[F_DM] ? base_q : 16'h8000;
            end
          end
        end
        default:
        begin
          if (ctk)
          begin
            cnt_q <= cnt_q + 9'h001;
            if (ctrl_q[F_DM])
            begin
              // Move toward the capacitance; halve the step unless fixed.
              dac_code <= cmp_s ? dac_code + step_q : dac_code - step_q;
              if (cnt_q[3:0] == DM_STEP_LEN && !ctrl_q[F_FIXG])
                step_q <= step_q >> 1;
            end
            else
            begin
              // Keep or clear the trial bit, try the next one.
              dac_code[bp] <= cmp_s;
              if (!last)
                dac_code[bp - 4'h1] <= 1'b1;
            end
            if (last)
            begin
              cnt_q <= 9'h000;
              step_q <= 16'(dmg_q) << (5'h10 - res_n);
              dac_code <= ctrl_q[F_DM] ? base_q : 16'h8000;
              acc_q <= acc_d;
              samp_q <= samp_q + 6'h01;
              // Accumulate 2^n samples, then shift or keep.
              if (samp_q == 6'((7'h01 << acc_log) - 7'h01))
              begin
                acc_q <= 22'h000000;
                samp_q <= 6'h00;
                fin_q <= ctrl_q[F_SHIFT] ? acc_d >> acc_log : acc_d;
                out_q <= 1'b1;
                // Scan on, repeat, or stop per mode.
                if (scan && !nc[6])
                begin
                  cur_q <= nc;
                  ch_mask <= 64'h1 << nc[5:0];
                end
                else if (mode == M_CSCAN && scan)
                begin
                  cur_q <= first;
                  ch_mask <= 64'h1 << first[5:0];
                end
                else if (mode == M_SINGLE || mode == M_SCAN)
                  st_q <= ST_IDLE;
              end
            end
          end
          if (stop_cmd)
            st_q <= ST_IDLE;
        end
      endcase
    end
  end

  sequence s_go;
    st_q == ST_IDLE && trig;
  endsequence
  sequence s_busy_trig;
    st_q != ST_IDLE && trig && !stop_cmd;
  endsequence
  trig_start_a: assert property (s_go |=> st_q != ST_IDLE)
    else $error("trigger did not start a cycle");
  idle_hold_a: assert property (st_q == ST_IDLE && !trig |=> st_q == ST_IDLE)
    else $error("cycle started without trigger");
  busy_ign_a: assert property (s_busy_trig ##1 (st_q == ST_IDLE && !trig) |=> st_q == ST_IDLE)
    else $error("busy trigger was queued");
  warm_pwr_a: assert property (st_q == ST_WARM |-> pwr_on)
    else $error("warm-up without power");
  warm_len_a: assert property (st_q == ST_IDLE ##1 st_q == ST_WARM
    |-> cnt_q == 9'h000)
    else $error("warm-up count not cleared");
  sar_len_a: assert property (st_q == ST_CONV && ctk && !ctrl_q[F_DM] && !stop_cmd
    && cnt_q < {4'h0, res_n - 5'h01} |=> st_q == ST_CONV && !out_q)
    else $error("SAR conversion ended early");

  logic signed [22:0] diff;
  logic above;
  assign diff = $signed({1'b0, fin_q}) - $signed({1'b0, ema_q});
  assign above = ctrl_q[F_POL] ? fin_q > {6'h00, thr_q} : fin_q < {6'h00, thr_q};
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_q <= 22'h000000;
      ema_q <= 22'h000000;
      above_q <= 1'b0;
      irq_done <= 1'b0;
      irq_cross <= 1'b0;
      dma_req <= 1'b0;
    end
    else
    begin
      irq_done <= out_q;
      irq_cross <= out_q && above != above_q;
      if (out_q)
      begin
        data_q <= fin_q;
        above_q <= above;
        ema_q <= (ctrl_q[F_EMA+:3] == 3'h0) ? fin_q
               : 22'(ema_q + 22'(diff >>> ctrl_q[F_EMA+:3]));
      end
      // A new result wins over an acknowledge in the same cycle.
      if (out_q && ctrl_q[F_DMA])
        dma_req <= 1'b1;
      else if (dma_ack)
        dma_req <= 1'b0;
    end
  end

  done_irq_a: assert property (out_q |=> irq_done && data_q == $past(fin_q))
    else $error("done request missing");
  dma_set_a: assert property (out_q && ctrl_q[F_DMA] |=> dma_req [*1])
    else $error("dma request missing");

  // Register writes; baseline also loads from the DMA port.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      evsel_q <= 3'h0;
      tim_q <= TIM_RST;
      single_q <= 6'h00;
      scan_q <= 64'h0;
      thr_q <= THR_RST;
      base_q <= 16'h0000;
      dmg_q <= 8'h00;
      dma_base_req <= 1'b0;
    end
    else
    begin
      if (wr)
      begin
        if (addr == A_CTRL)
          ctrl_q <= wdata[CTRL_W-1:0];
        else if (addr == A_EVSEL)
          evsel_q <= (wdata < 32'(EVT_N)) ? wdata[2:0] : 3'h0;
        else if (addr == A_TIM)
          tim_q <= wdata[23:0];
        else if (addr == A_SINGLE)
          single_q <= wdata[5:0];
        else if (addr == A_SCANLO)
          scan_q[31:0] <= wdata;
        else if (addr == A_SCANHI)
          scan_q[63:32] <= wdata;
        else if (addr == A_THR)
          thr_q <= wdata[15:0];
        else if (addr == A_BASE)
          base_q <= wdata[15:0];
        else if (addr == A_DMCFG)
          dmg_q <= wdata[7:0];
      end
      // Ask for a baseline at each delta-modulation trigger.
      if (go && ctrl_q[F_DM] && ctrl_q[F_DMA])
        dma_base_req <= 1'b1;
      else if (dma_base_wr)
        dma_base_req <= 1'b0;
      if (dma_base_wr)
        base_q <= dma_base_data;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (!rd)
      rdata <= 32'h0;
    else if (addr == A_CTRL)
      rdata <= {13'h0, ctrl_q};
    else if (addr == A_STAT)
      rdata <= {26'h0, above_q, pwr_on, cur_q[5:0] == 6'h00 && 1'b0, st_q != ST_IDLE, st_q};
    else if (addr == A_EVSEL)
      rdata <= {29'h0, evsel_q};
    else if (addr == A_TIM)
      rdata <= {8'h0, tim_q};
    else if (addr == A_SINGLE)
      rdata <= {26'h0, single_q};
    else if (addr == A_SCANLO)
      rdata <= scan_q[31:0];
    else if (addr == A_SCANHI)
      rdata <= scan_q[63:32];
    else if (addr == A_THR)
      rdata <= {16'h0, thr_q};
    else if (addr == A_BASE)
      rdata <= {16'h0, base_q};
    else if (addr == A_DMCFG)
      rdata <= {24'h0, dmg_q};
    else if (addr == A_DATA)
      rdata <= {10'h0, data_q};
    else if (addr == A_EMA)
      rdata <= {10'h0, ema_q};
    else
      rdata <= 32'h0;
  end

  rd_data_a: assert property (rd && addr == A_DATA |=> rdata == {10'h0, $past(data_q)})
    else $error("data read mismatch");
endmodule

// file: electrode_model.sv
`timescale 1ns/1ps
module electrode_model
(
  // Clock.
  input wire logic core_clk,
  // Analog core side.
  input wire logic pwr_on,
  input wire logic [63:0] ch_mask,
  input wire logic [15:0] dac_code,
  output logic cmp_in
);
  logic [19:0] cap_sum;
  logic noise_q = 1'b0;

  // Each electrode has a fixed capacitance in code units plus half a code.
  function automatic logic [15:0] cap_of(input int i);
    case (i)
      1: return 16'h1203;
      4: return 16'h2345;
      5: return 16'h5a61;
      default: return 16'h0400;
    endcase
  endfunction

  always_comb
  begin
    cap_sum = 20'h00000;
    for (int i = 0; i < 64; i++)
      if (ch_mask[i])
        cap_sum = cap_sum + {4'h0, cap_of(i)};
  end

  // An unpowered or unconnected comparator gives no steady answer.
  always_ff @(posedge core_clk)
    noise_q <= ~noise_q;

  // The extra half code makes a code equal to the capacitance count as below it.
  assign cmp_in = (pwr_on && ch_mask != 64'h0) ? (cap_sum >= {4'h0, dac_code}) : noise_q;
endmodule

// file: cap_sense_trigger_timing_test.sv
`timescale 1ns/1ps
module cap_sense_trigger_timing_test;
  import cts_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic lf_clk = 1'b0;
  logic cv_clk = 1'b0;
  logic [7:0] evt = 8'h00;
  logic cmp_in, pwr_on, irq_done, irq_cross, dma_req, dma_base_req;
  logic [63:0] ch_mask;
  logic [15:0] dac_code;
  logic dma_ack = 1'b0;
  logic dma_base_wr = 1'b0;
  logic [15:0] dma_base_data = 16'h0000;
  int err_count = 0;
  int cmp_count = 0;
  int done_cnt = 0;
  int cross_cnt = 0;
  int d = 0;
  int c = 0;
  time last_t = 0;
  time prev_t = 0;

  // Core, low-frequency and conversion clocks run at unrelated rates.
  always #5 core_clk = ~core_clk;
  always #100 lf_clk = ~lf_clk;
  always #37 cv_clk = ~cv_clk;

  cap_touch_unit uut
  (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .low_freq_timer_clock(lf_clk), .conversion_clock(cv_clk),
    .event_routing_network(evt), .cmp_in(cmp_in), .pwr_on(pwr_on), .ch_mask(ch_mask),
    .dac_code(dac_code), .irq_done(irq_done), .irq_cross(irq_cross), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_base_req(dma_base_req), .dma_base_wr(dma_base_wr),
    .dma_base_data(dma_base_data)
  );

  electrode_model partner
  (
    .core_clk(core_clk), .pwr_on(pwr_on), .ch_mask(ch_mask), .dac_code(dac_code),
    .cmp_in(cmp_in)
  );

  // Count completion and crossing pulses and note when words arrive.
  always @(posedge core_clk)
  begin
    if (irq_done === 1'b1)
    begin
      done_cnt++;
      prev_t = last_t;
      last_t = $time;
    end
    if (irq_cross === 1'b1)
      cross_cnt++;
  end

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write cycle, then a quiet cycle so strobes never merge.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge core_clk);
  endtask

  task automatic wait_done(input int n);
    int lim;
    lim = 0;
    while (done_cnt < n && lim < 20000)
    begin
      @(posedge core_clk);
      lim++;
    end
    if (lim == 20000)
    begin
      err_count++;
      finish_test();
    end
  endtask

  // Waits for n words since the mark, then makes sure no further word follows.
  task automatic settle(input int n);
    wait_done(d + n);
    repeat (300) @(posedge core_clk);
    check(done_cnt - d, n);
  endtask

  task automatic run_sw(input logic [31:0] ctrl, input int n, input logic [31:0] exp);
    d = done_cnt;
    wr_reg(A_CTRL, ctrl);
    wr_reg(A_CMD, 32'h1);
    settle(n);
    rd_chk(A_DATA, exp);
  endtask

  // Main sequence of register-level scenarios.
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(A_CTRL, 32'h0);
    rd_chk(A_TIM, 32'hff);
    rd_chk(8'h3c, 32'h0);
    wr_reg(A_SINGLE, 32'h5);
    d = done_cnt;
    wr_reg(A_CMD, 32'h1);
    rd_chk(A_STAT, 32'h15);
    wr_reg(A_CMD, 32'h1);
    settle(1);
    for (int n = 0; n < 4; n++)
      run_sw(n << F_RES, 1, 32'h5a61 >> (6 - 2 * n));
    run_sw(32'h2 << F_ACC, 1, 32'h5a4);
    run_sw((32'h2 << F_ACC) | (32'h1 << F_SHIFT), 1, 32'h169);
    wr_reg(A_SCANLO, 32'h12);
    run_sw(32'h2 << F_MODE, 2, 32'h8d);
    run_sw((32'h2 << F_MODE) | (32'h1 << F_BOND), 1, 32'hd5);
    for (int m = 1; m < 4; m += 2)
    begin
      d = done_cnt;
      wr_reg(A_CTRL, m << F_MODE);
      wr_reg(A_CMD, 32'h1);
      wait_done(d + 3);
      wr_reg(A_CMD, 32'h2);
      rd_chk(A_STAT, 32'h0);
      d = done_cnt;
      settle(0);
    end
    wr_reg(A_THR, 32'h100);
    for (int k = 0; k < 3; k++)
    begin
      c = cross_cnt;
      run_sw(32'(k < 2) << F_POL, 1, 32'h169);
      check(cross_cnt - c, 32'(k != 1));
      rd_chk(A_STAT, (k < 2) ? 32'h20 : 32'h0);
    end
    // Filter with shift one: old average 0x169, new word 0x5a6.
    run_sw((32'h1 << F_EMA) | (32'h1 << F_RES), 1, 32'h5a6);
    rd_chk(A_EMA, 32'h387);
    wr_reg(A_EVSEL, 32'h9);
    rd_chk(A_EVSEL, 32'h0);
    wr_reg(A_EVSEL, 32'h3);
    wr_reg(A_CTRL, 32'h1);
    d = done_cnt;
    for (int b = 2; b < 4; b++)
    begin
      evt <= 8'h01 << b;
      repeat (4) @(posedge core_clk);
      evt <= 8'h00;
      @(posedge core_clk);
      settle(b - 2);
    end
    for (int t = 0; t < 2; t++)
    begin
      wr_reg(A_TIM, (t == 1) ? 32'h203 : 32'h7);
      wr_reg(A_CTRL, (32'h2 << F_SRC) | (32'h1 << F_KEEP));
      d = done_cnt;
      wait_done(d + 3);
      check(32'((last_t - prev_t + 100) / 200), (t == 1) ? 32'd16 : 32'd8);
    end
    wr_reg(A_CTRL, 32'h3 | (32'h1 << F_KEEP));
    wr_reg(A_CMD, 32'h2);
    rd_chk(A_STAT, 32'h10);
    wr_reg(A_DMCFG, 32'h1);
    for (int f = 0; f < 2; f++)
    begin
      d = done_cnt;
      wr_reg(A_CTRL, (32'h1 << F_DM) | (32'h1 << F_DMA) | (32'(f) << F_FIXG));
      wr_reg(A_CMD, 32'h1);
      #1;
      check({31'h0, dma_base_req}, 32'h1);
      dma_base_data <= 16'h5a61;
      dma_base_wr <= 1'b1;
      @(posedge core_clk);
      dma_base_wr <= 1'b0;
      settle(1);
      check({31'h0, dma_req}, 32'h1);
      dma_ack <= 1'b1;
      @(posedge core_clk);
      dma_ack <= 1'b0;
      @(posedge core_clk);
      #1;
      check({30'h0, dma_req, dma_base_req}, 32'h0);
      @(posedge core_clk);
      rd_chk(A_BASE, 32'h5a61);
    end
    finish_test();
  end
endmodule
